// ===== rtl/otss_top.sv
// Function
// - Seven terminals with codes reset to 0, 1, 2, 3, 4, 99, 9999.
// - Code 9999 selects nothing; terminal stays inactive.
// - Codes 0-13 (not 7 or 9) and 99 select flag directly; 100-199 select code minus 100 inverted.
// - Running flag: operating and output frequency at or above starting frequency.
// - At-speed flag: output frequency has reached the set frequency.
// - Power-loss flag: instantaneous power failure or undervoltage protection active.
// - Stall alarm flag: true while stall prevention is active.
// - Frequency detect flag vs detection level; reverse uses its own level.
// - Second and third detect flags each compare against own level.
// - Thermal prealarm at 85 percent of trip; protection trips at 100.
// - Panel mode flag: true while panel operation mode is selected.
// - Ready flag only after power-up and reset done, while startable or running.
// - Overcurrent flag: current above threshold longer than configured time.
// - Zero current flag: output power below threshold longer than configured time.
`include "otss_regs.svh"
module otss_top #(
  parameter int FW          = 16,
  parameter int TICK_CYCLES = `OTSS_TICK_NS / `OTSS_CLK_NS
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rstn_i,
  // AXI4-Lite write address
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // Drive status
  input  wire logic          running_i,
  input  wire logic          reverse_i,
  input  wire logic [FW-1:0] out_freq_i,
  input  wire logic [FW-1:0] set_freq_i,
  input  wire logic          inst_pwr_fail_i,
  input  wire logic          undervolt_i,
  input  wire logic          stall_active_i,
  input  wire logic [15:0]   thermal_i,
  input  wire logic          panel_mode_i,
  input  wire logic          reset_done_i,
  input  wire logic          startable_i,
  input  wire logic [15:0]   out_current_i,
  input  wire logic [15:0]   out_power_i,
  input  wire logic          fault_i,
  // Terminals and events
  output logic [6:0]         term_o,
  output logic               thermal_trip_o,
  output logic               irq_o
);
  import otss_pkg::*;

  localparam int NT  = `OTSS_NUM_TERM;
  localparam int TCW = $clog2(TICK_CYCLES + 1);

  // Power-up codes
  localparam otss_code_t FUNC_RST [NT] = '{
    `OTSS_RST_F0, `OTSS_RST_F1, `OTSS_RST_F2, `OTSS_RST_F3,
    `OTSS_RST_F4, `OTSS_RST_F5, `OTSS_RST_F6
  };

  otss_code_t     func [NT];
  logic [FW-1:0]  start_freq, det_freq, det_rev, det2_freq, det3_freq;
  logic [15:0]    trip_level, curr_level, curr_time, zero_level, zero_time, irq_mask, irq_stat;
  otss_flags_t    flags, flags_q;
  logic [NT-1:0]  next_term;
  logic           ready_armed, overcur_hit, zerocur_hit, tick;
  logic [TCW-1:0] tick_cnt;
  otss_wr_t       wr_state;
  otss_rd_t       rd_state;
  logic           aw_got, w_got, do_write, wr_ok, rd_ok;
  logic [7:0]     aw_addr_q;
  logic [31:0]    w_data_q, next_rdata;
  logic [3:0]     w_strb_q;
  logic [15:0]    w16, irq_clr;

  //////////////////////////////////////////////////////////////////////////////
  // Time base for the persistence timers
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tick_cnt <= '0;
    end else if (tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
    end
  end

  assign tick = (tick_cnt == TCW'(TICK_CYCLES - 1));

  //////////////////////////////////////////////////////////////////////////////
  // Status flags
  // Ready is held off until the reset process has finished once
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ready_armed <= 1'b0;
    end else if (reset_done_i) begin
      ready_armed <= 1'b1;
    end
  end

  otss_persist u_overcur (
    .clk_i (clk_i),
    .rstn_i(rstn_i),
    .tick_i(tick),
    .cond_i(out_current_i > curr_level),
    .time_i(curr_time),
    .hit_o (overcur_hit)
  );

  otss_persist u_zerocur (
    .clk_i (clk_i),
    .rstn_i(rstn_i),
    .tick_i(tick),
    .cond_i(out_power_i < zero_level),
    .time_i(zero_time),
    .hit_o (zerocur_hit)
  );

  always_comb begin
    flags = '0;
    flags[`OTSS_B_RUN]      = running_i && (out_freq_i >= start_freq);
    flags[`OTSS_B_AT_SPEED] = out_freq_i >= set_freq_i;
    flags[`OTSS_B_PWR_LOSS] = inst_pwr_fail_i | undervolt_i;
    flags[`OTSS_B_STALL]    = stall_active_i;
    flags[`OTSS_B_FDET]     = reverse_i ? (out_freq_i >= det_rev) : (out_freq_i >= det_freq);
    flags[`OTSS_B_FDET2]    = out_freq_i >= det2_freq;
    flags[`OTSS_B_FDET3]    = out_freq_i >= det3_freq;
    flags[`OTSS_B_THERM]    = otss_pct(thermal_i, `OTSS_PCT_TRIP) >=
                              otss_pct(trip_level, `OTSS_PCT_PREALARM);
    flags[`OTSS_B_PANEL]    = panel_mode_i;
    flags[`OTSS_B_READY]    = ready_armed && (startable_i || running_i);
    flags[`OTSS_B_OVERCUR]  = overcur_hit;
    flags[`OTSS_B_ZEROCUR]  = zerocur_hit;
    flags[`OTSS_B_FAULT]    = fault_i | thermal_trip_o;
  end

  // A full thermal count is a trip and therefore also raises the fault flag
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      thermal_trip_o <= 1'b0;
    end else begin
      thermal_trip_o <= otss_pct(thermal_i, `OTSS_PCT_TRIP) >=
                        otss_pct(trip_level, `OTSS_PCT_TRIP);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Terminal routing
  for (genvar t = 0; t < NT; t++) begin : g_term
    otss_term_sel u_sel (
      .code_i  (func[t]),
      .flags_i (flags),
      .active_o(next_term[t])
    );
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      term_o <= '0;
    end else begin
      term_o <= next_term;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupts on rising flag edges
  // A new edge in the clearing cycle survives the clear
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flags_q  <= '0;
      irq_stat <= '0;
      irq_o    <= 1'b0;
    end else begin
      flags_q  <= flags;
      irq_stat <= (irq_stat & ~irq_clr) | (flags & ~flags_q);
      irq_o    <= |(irq_stat & irq_mask);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write side
  assign s_axi_awready = (wr_state == OTSS_WR_IDLE) && !aw_got;
  assign s_axi_wready  = (wr_state == OTSS_WR_IDLE) && !w_got;
  assign s_axi_bvalid  = (wr_state == OTSS_WR_RESP);
  assign do_write      = (wr_state == OTSS_WR_IDLE) && aw_got && w_got;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_got    <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got    <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_got    <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      w_got    <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got    <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_got    <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_state    <= OTSS_WR_IDLE;
      s_axi_bresp <= `OTSS_RESP_OKAY;
    end else begin
      case (wr_state)
        OTSS_WR_IDLE: begin
          if (do_write) begin
            wr_state    <= OTSS_WR_RESP;
            s_axi_bresp <= wr_ok ? `OTSS_RESP_OKAY : `OTSS_RESP_SLVERR;
          end
        end
        OTSS_WR_RESP: begin
          if (s_axi_bready) begin
            wr_state <= OTSS_WR_IDLE;
          end
        end
        default: wr_state <= OTSS_WR_IDLE;
      endcase
    end
  end

  always_comb begin
    w16     = 16'(otss_merge(32'h0000_0000, w_data_q, w_strb_q));
    irq_clr = '0;
    if (do_write && aw_addr_q == `OTSS_A_IRQ_STAT) begin
      irq_clr = w16;
    end
    wr_ok = (aw_addr_q <= `OTSS_A_IRQ_MASK) && (aw_addr_q[1:0] == 2'b00) &&
            (aw_addr_q != `OTSS_A_FLAGS) && (aw_addr_q != `OTSS_A_TERM);
  end

  // Byte strobes apply to the two low lanes; upper lanes hold nothing
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int t = 0; t < NT; t++) begin
        func[t] <= FUNC_RST[t];
      end
    end else if (do_write && aw_addr_q <= `OTSS_A_FUNC6 && aw_addr_q[1:0] == 2'b00) begin
      func[aw_addr_q[4:2]] <= otss_code_t'(otss_merge(32'(func[aw_addr_q[4:2]]), w_data_q, w_strb_q));
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      start_freq <= FW'(`OTSS_RST_FREQ);
      det_freq   <= FW'(`OTSS_RST_FREQ);
      det_rev    <= FW'(`OTSS_RST_FREQ);
      det2_freq  <= FW'(`OTSS_RST_FREQ);
      det3_freq  <= FW'(`OTSS_RST_FREQ);
      trip_level <= `OTSS_RST_TRIP;
      curr_level <= `OTSS_RST_LEVEL;
      curr_time  <= `OTSS_RST_TIME;
      zero_level <= '0;
      zero_time  <= `OTSS_RST_TIME;
      irq_mask   <= `OTSS_RST_MASK;
    end else if (do_write) begin
      case (aw_addr_q)
        `OTSS_A_START_FREQ: start_freq <= FW'(otss_merge(32'(start_freq), w_data_q, w_strb_q));
        `OTSS_A_DET_FREQ:   det_freq   <= FW'(otss_merge(32'(det_freq), w_data_q, w_strb_q));
        `OTSS_A_DET_REV:    det_rev    <= FW'(otss_merge(32'(det_rev), w_data_q, w_strb_q));
        `OTSS_A_DET2_FREQ:  det2_freq  <= FW'(otss_merge(32'(det2_freq), w_data_q, w_strb_q));
        `OTSS_A_DET3_FREQ:  det3_freq  <= FW'(otss_merge(32'(det3_freq), w_data_q, w_strb_q));
        `OTSS_A_TRIP_LEVEL: trip_level <= 16'(otss_merge(32'(trip_level), w_data_q, w_strb_q));
        `OTSS_A_CURR_LEVEL: curr_level <= 16'(otss_merge(32'(curr_level), w_data_q, w_strb_q));
        `OTSS_A_CURR_TIME:  curr_time  <= 16'(otss_merge(32'(curr_time), w_data_q, w_strb_q));
        `OTSS_A_ZERO_LEVEL: zero_level <= 16'(otss_merge(32'(zero_level), w_data_q, w_strb_q));
        `OTSS_A_ZERO_TIME:  zero_time  <= 16'(otss_merge(32'(zero_time), w_data_q, w_strb_q));
        `OTSS_A_IRQ_MASK:   irq_mask   <= 16'(otss_merge(32'(irq_mask), w_data_q, w_strb_q));
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read side
  assign s_axi_arready = (rd_state == OTSS_RD_IDLE);
  assign s_axi_rvalid  = (rd_state == OTSS_RD_DATA);

  always_comb begin
    next_rdata = '0;
    rd_ok      = (s_axi_araddr[1:0] == 2'b00);
    if (s_axi_araddr <= `OTSS_A_FUNC6) begin
      next_rdata = 32'(func[s_axi_araddr[4:2]]);
    end else begin
      case (s_axi_araddr)
        `OTSS_A_START_FREQ: next_rdata = 32'(start_freq);
        `OTSS_A_DET_FREQ:   next_rdata = 32'(det_freq);
        `OTSS_A_DET_REV:    next_rdata = 32'(det_rev);
        `OTSS_A_DET2_FREQ:  next_rdata = 32'(det2_freq);
        `OTSS_A_DET3_FREQ:  next_rdata = 32'(det3_freq);
        `OTSS_A_TRIP_LEVEL: next_rdata = 32'(trip_level);
        `OTSS_A_CURR_LEVEL: next_rdata = 32'(curr_level);
        `OTSS_A_CURR_TIME:  next_rdata = 32'(curr_time);
        `OTSS_A_ZERO_LEVEL: next_rdata = 32'(zero_level);
        `OTSS_A_ZERO_TIME:  next_rdata = 32'(zero_time);
        `OTSS_A_FLAGS:      next_rdata = 32'(flags);
        `OTSS_A_TERM:       next_rdata = 32'(term_o);
        `OTSS_A_IRQ_STAT:   next_rdata = 32'(irq_stat);
        `OTSS_A_IRQ_MASK:   next_rdata = 32'(irq_mask);
        default:            rd_ok      = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_state    <= OTSS_RD_IDLE;
      s_axi_rdata <= '0;
      s_axi_rresp <= `OTSS_RESP_OKAY;
    end else begin
      case (rd_state)
        OTSS_RD_IDLE: begin
          if (s_axi_arvalid) begin
            rd_state    <= OTSS_RD_DATA;
            s_axi_rdata <= rd_ok ? next_rdata : 32'h0000_0000;
            s_axi_rresp <= rd_ok ? `OTSS_RESP_OKAY : `OTSS_RESP_SLVERR;
          end
        end
        OTSS_RD_DATA: begin
          if (s_axi_rready) begin
            rd_state <= OTSS_RD_IDLE;
          end
        end
        default: rd_state <= OTSS_RD_IDLE;
      endcase
    end
  end

endmodule

// ===== rtl/otss_regs.svh
`ifndef OTSS_REGS_SVH
`define OTSS_REGS_SVH

// Register byte offsets
`define OTSS_A_FUNC0      8'h00
`define OTSS_A_FUNC1      8'h04
`define OTSS_A_FUNC2      8'h08
`define OTSS_A_FUNC3      8'h0c
`define OTSS_A_FUNC4      8'h10
`define OTSS_A_FUNC6      8'h18
`define OTSS_A_START_FREQ 8'h1c
`define OTSS_A_DET_FREQ   8'h20
`define OTSS_A_DET_REV    8'h24
`define OTSS_A_DET2_FREQ  8'h28
`define OTSS_A_DET3_FREQ  8'h2c
`define OTSS_A_TRIP_LEVEL 8'h30
`define OTSS_A_CURR_LEVEL 8'h34
`define OTSS_A_CURR_TIME  8'h38
`define OTSS_A_ZERO_LEVEL 8'h3c
`define OTSS_A_ZERO_TIME  8'h40
`define OTSS_A_FLAGS      8'h44
`define OTSS_A_TERM       8'h48
`define OTSS_A_IRQ_STAT   8'h4c
`define OTSS_A_IRQ_MASK   8'h50

// Terminal codes after reset
`define OTSS_NUM_TERM     7
`define OTSS_RST_F0       14'd0
`define OTSS_RST_F1       14'd1
`define OTSS_RST_F2       14'd2
`define OTSS_RST_F3       14'd3
`define OTSS_RST_F4       14'd4
`define OTSS_RST_F5       14'd99
`define OTSS_RST_F6       14'd9999

// Other reset values
`define OTSS_RST_FREQ     16'h0000
`define OTSS_RST_TRIP     16'hffff
`define OTSS_RST_LEVEL    16'hffff
`define OTSS_RST_TIME     16'h000a
`define OTSS_RST_MASK     16'h0000

// Function codes
`define OTSS_CODE_RUN     14'd0
`define OTSS_CODE_MAXFLG  14'd13
`define OTSS_CODE_GAP1    14'd7
`define OTSS_CODE_GAP2    14'd9
`define OTSS_CODE_FAULT   14'd99
`define OTSS_CODE_NEG_LO  14'd100
`define OTSS_CODE_NEG_HI  14'd199
`define OTSS_IDX_FAULT    4'd14

// Flag bit positions
`define OTSS_B_RUN        0
`define OTSS_B_AT_SPEED   1
`define OTSS_B_PWR_LOSS   2
`define OTSS_B_STALL      3
`define OTSS_B_FDET       4
`define OTSS_B_FDET2      5
`define OTSS_B_FDET3      6
`define OTSS_B_THERM      8
`define OTSS_B_PANEL      10
`define OTSS_B_READY      11
`define OTSS_B_OVERCUR    12
`define OTSS_B_ZEROCUR    13
`define OTSS_B_FAULT      14

// Thermal levels in percent
`define OTSS_PCT_PREALARM 7'd85
`define OTSS_PCT_TRIP     7'd100

// Timing
`define OTSS_CLK_NS       4
`define OTSS_TICK_NS      100000

// Bus answers
`define OTSS_RESP_OKAY    2'b00
`define OTSS_RESP_SLVERR  2'b10

`endif

// ===== rtl/otss_pkg.sv
`include "otss_regs.svh"

package otss_pkg;

  typedef logic [13:0] otss_code_t;
  typedef logic [15:0] otss_flags_t;

  typedef struct packed {
    logic       valid;
    logic       invert;
    logic [3:0] idx;
  } otss_sel_t;

  typedef enum logic {
    OTSS_WR_IDLE = 1'b0,
    OTSS_WR_RESP = 1'b1
  } otss_wr_t;

  typedef enum logic {
    OTSS_RD_IDLE = 1'b0,
    OTSS_RD_DATA = 1'b1
  } otss_rd_t;

  // Unknown or unassigned codes decode as invalid and leave the terminal off
  function automatic otss_sel_t otss_decode(input otss_code_t c);
    otss_sel_t  s;
    otss_code_t b;
    s = '0;
    b = c;
    if (c >= `OTSS_CODE_NEG_LO && c <= `OTSS_CODE_NEG_HI) begin
      s.invert = 1'b1;
      b        = c - `OTSS_CODE_NEG_LO;
    end
    if (b <= `OTSS_CODE_MAXFLG && b != `OTSS_CODE_GAP1 && b != `OTSS_CODE_GAP2) begin
      s.valid = 1'b1;
      s.idx   = b[3:0];
    end else if (b == `OTSS_CODE_FAULT) begin
      s.valid = 1'b1;
      s.idx   = `OTSS_IDX_FAULT;
    end
    return s;
  endfunction

  function automatic logic [31:0] otss_merge(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] otss_pct(input logic [15:0] v, input logic [6:0] pct);
    return 32'(v) * 32'(pct);
  endfunction

endpackage

// ===== rtl/otss_term_sel.sv
module otss_term_sel (
  // Selection
  input  wire otss_pkg::otss_code_t  code_i,
  input  wire otss_pkg::otss_flags_t flags_i,
  // Result
  output logic                       active_o
);
  import otss_pkg::*;

  otss_sel_t sel;

  always_comb begin
    sel      = otss_decode(code_i);
    active_o = sel.valid & (flags_i[sel.idx] ^ sel.invert);
  end

endmodule

// ===== rtl/otss_persist.sv
module otss_persist #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  // Condition and time
  input  wire logic         tick_i,
  input  wire logic         cond_i,
  input  wire logic [W-1:0] time_i,
  // Result
  output logic              hit_o
);
  import otss_pkg::*;

  logic [W-1:0] cnt;

  // Any break in the condition restarts the count
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= '0;
    end else if (!cond_i) begin
      cnt <= '0;
    end else if (tick_i && cnt != '1) begin
      cnt <= cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hit_o <= 1'b0;
    end else begin
      hit_o <= cond_i && (cnt > time_i);
    end
  end

endmodule

// ===== verif/otss_equip.sv
module otss_equip (
  // Terminals from the drive
  input  wire logic [6:0] term_i,
  // Loads as the equipment sees them
  output logic      [6:0] load_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Open collector sinks its pull-up when active, a relay closes its contact; both read as 1 here
  assign load_o = term_i;
endmodule

// ===== verif/otss_top_asserts.sv
module otss_top_asserts #(
  parameter int FW = 16
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rstn_i,
  // Bus
  input  wire logic          s_axi_awvalid,
  input  wire logic          s_axi_awready,
  input  wire logic          s_axi_wvalid,
  input  wire logic          s_axi_wready,
  input  wire logic [1:0]    s_axi_bresp,
  input  wire logic          s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [31:0]   s_axi_rdata,
  input  wire logic          s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // Status
  input  wire logic          running_i,
  input  wire logic [FW-1:0] out_freq_i,
  input  wire logic [FW-1:0] set_freq_i,
  input  wire logic          inst_pwr_fail_i,
  input  wire logic          undervolt_i,
  input  wire logic          stall_active_i,
  input  wire logic [15:0]   thermal_i,
  // Outputs
  input  wire logic [6:0]    term_o,
  input  wire logic          thermal_trip_o,
  input  wire logic          irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Routing checks only hold while every register keeps its reset value
  logic armed;
  logic dflt;
  logic q_spd;
  logic q_trip;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      armed <= 1'b0;
      dflt  <= 1'b1;
    end else begin
      armed <= 1'b1;
      if (s_axi_awvalid && s_axi_awready) begin
        dflt <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q_spd  <= 1'b0;
      q_trip <= 1'b0;
    end else begin
      q_spd  <= out_freq_i >= set_freq_i;
      q_trip <= thermal_i == 16'hffff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_dflt;
    armed && dflt;
  endsequence
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  a_run_route: assert property (s_dflt |-> term_o[0] == $past(running_i))
    else $error("run terminal wrong");
  a_atspd_route: assert property (s_dflt |-> term_o[1] == q_spd)
    else $error("at speed terminal wrong");
  a_pwr_route: assert property (s_dflt |-> term_o[2] == ($past(inst_pwr_fail_i) || $past(undervolt_i)))
    else $error("power loss terminal wrong");
  a_stall_route: assert property (s_dflt |-> term_o[3] == $past(stall_active_i))
    else $error("stall terminal wrong");
  a_fdet_zero: assert property (s_dflt |-> term_o[4])
    else $error("detect terminal low at zero level");
  a_nofunc_idle: assert property (s_dflt |-> !term_o[6] && !irq_o)
    else $error("unassigned terminal active");
  a_trip_level: assert property (s_dflt |-> thermal_trip_o == q_trip)
    else $error("thermal trip wrong");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_wr_answer: assert property (s_wr_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write not answered");
endmodule

bind otss_top otss_top_asserts #(.FW(FW)) u_otss_top_asserts (.*);

// ===== verif/test_output_terminal_status_select.sv
`include "otss_regs.svh"
module test_output_terminal_status_select;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, rstn_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, running_i, reverse_i;
  logic        inst_pwr_fail_i, undervolt_i, stall_active_i, panel_mode_i, reset_done_i, startable_i;
  logic        fault_i, thermal_trip_o, irq_o;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [15:0] out_freq_i, set_freq_i, thermal_i, out_current_i, out_power_i;
  logic [6:0]  term_o, load;
  int          n_errors, compares;

  otss_top #(.FW(16), .TICK_CYCLES(4)) u_otss_top (.*);
  otss_equip u_otss_equip (.term_i(term_o), .load_o(load));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Bounded waits: a slave that never answers ends the run
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 50) begin
      n_errors++;
      conclude();
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdw(input logic [7:0] a);
    int n;
    @(posedge clk_i);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 50) begin
      n_errors++;
      conclude();
    end
    rd   = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic set(input logic [7:0] a, input logic [31:0] d);
    wr(a, d);
    chk(32'(resp), 32'(`OTSS_RESP_OKAY));
  endtask

  task automatic tb(input int t, input logic e);
    tk(2);
    chk({31'h0, load[t]}, {31'h0, e});
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic s_defaults();
    logic [13:0] rv [7];
    rv = '{14'd0, 14'd1, 14'd2, 14'd3, 14'd4, 14'd99, 14'd9999};
    for (int i = 0; i < 7; i++) begin
      rdw(8'(4 * i));
      chk(rd, {18'h0, rv[i]});
    end
    rdw(`OTSS_A_TRIP_LEVEL);
    chk(rd, 32'h0000ffff);
    running_i      <= 1'b1;
    fault_i        <= 1'b1;
    stall_active_i <= 1'b1;
    undervolt_i    <= 1'b1;
    out_freq_i     <= 16'h0014;
    set_freq_i     <= 16'h000a;
    tk(2);
    chk({25'h0, load}, 32'h3f);
    running_i       <= 1'b0;
    fault_i         <= 1'b0;
    stall_active_i  <= 1'b0;
    undervolt_i     <= 1'b0;
    inst_pwr_fail_i <= 1'b1;
    set_freq_i      <= 16'h001e;
    tk(2);
    chk({25'h0, load}, 32'h14);
    inst_pwr_fail_i <= 1'b0;
  endtask

  task automatic s_polarity();
    set(`OTSS_A_FUNC0, 32'd103);
    tb(0, 1'b1);
    stall_active_i <= 1'b1;
    tb(0, 1'b0);
    stall_active_i <= 1'b0;
    set(`OTSS_A_FUNC0, 32'd0);
  endtask

  task automatic s_freq();
    set(`OTSS_A_START_FREQ, 32'd150);
    running_i  <= 1'b1;
    out_freq_i <= 16'd100;
    tb(0, 1'b0);
    out_freq_i <= 16'd150;
    tb(0, 1'b1);
    out_freq_i <= 16'd100;
    set(`OTSS_A_DET_FREQ, 32'd50);
    set(`OTSS_A_DET_REV, 32'd200);
    tb(4, 1'b1);
    reverse_i <= 1'b1;
    tb(4, 1'b0);
    reverse_i <= 1'b0;
    set(`OTSS_A_DET2_FREQ, 32'd100);
    set(`OTSS_A_FUNC1, 32'd5);
    tb(1, 1'b1);
    set(`OTSS_A_DET3_FREQ, 32'd101);
    set(`OTSS_A_FUNC6, 32'd6);
    tb(6, 1'b0);
    out_freq_i <= 16'd101;
    tb(6, 1'b1);
  endtask

  task automatic s_status();
    set(`OTSS_A_TRIP_LEVEL, 32'd100);
    set(`OTSS_A_FUNC2, 32'd8);
    thermal_i <= 16'd84;
    tb(2, 1'b0);
    thermal_i <= 16'd85;
    tb(2, 1'b1);
    chk({31'h0, thermal_trip_o}, 32'h0);
    thermal_i <= 16'd100;
    tk(2);
    chk({31'h0, thermal_trip_o}, 32'h1);
    thermal_i <= 16'd0;
    set(`OTSS_A_FUNC4, 32'd10);
    panel_mode_i <= 1'b1;
    tb(4, 1'b1);
    panel_mode_i <= 1'b0;
    tb(4, 1'b0);
    set(`OTSS_A_FUNC3, 32'd11);
    tb(3, 1'b0);
    reset_done_i <= 1'b1;
    tk(1);
    reset_done_i <= 1'b0;
    tb(3, 1'b1);
    running_i <= 1'b0;
    tb(3, 1'b0);
    startable_i <= 1'b1;
    tb(3, 1'b1);
  endtask

  // Long enough to pass the set persistence with a few ticks of margin
  task automatic s_timers();
    set(`OTSS_A_CURR_LEVEL, 32'd50);
    set(`OTSS_A_CURR_TIME, 32'd2);
    set(`OTSS_A_FUNC0, 32'd12);
    out_current_i <= 16'd51;
    tb(0, 1'b0);
    tk(40);
    tb(0, 1'b1);
    set(`OTSS_A_ZERO_LEVEL, 32'd10);
    set(`OTSS_A_FUNC1, 32'd13);
    out_power_i <= 16'd5;
    tb(1, 1'b0);
    tk(70);
    tb(1, 1'b1);
  endtask

  task automatic s_bus_irq();
    set(`OTSS_A_IRQ_MASK, 32'h8);
    stall_active_i <= 1'b1;
    tk(4);
    chk({31'h0, irq_o}, 32'h1);
    set(`OTSS_A_IRQ_STAT, 32'h8);
    tk(3);
    chk({31'h0, irq_o}, 32'h0);
    wr(`OTSS_A_FLAGS, 32'h0);
    chk(32'(resp), 32'(`OTSS_RESP_SLVERR));
    rdw(8'hfc);
    chk(32'(resp), 32'(`OTSS_RESP_SLVERR));
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  initial begin
    {rstn_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {running_i, reverse_i, inst_pwr_fail_i, undervolt_i, stall_active_i, panel_mode_i} = '0;
    {reset_done_i, startable_i, fault_i, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {out_freq_i, set_freq_i, thermal_i, out_current_i} = '0;
    out_power_i = 16'h0064;
    s_axi_wstrb = 4'hf;
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    s_defaults();
    s_polarity();
    s_freq();
    s_status();
    s_timers();
    s_bus_irq();
    conclude();
  end
endmodule
